//--- inc/spb_pkg.sv
// Package: register map, field layout and timing constants of the serial port.
package spb_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_TXBUF = 8'h00;
    localparam logic [7:0] OFF_RXBUF = 8'h04;
    localparam logic [7:0] OFF_LCR = 8'h08;
    localparam logic [7:0] OFF_ICR = 8'h0C;
    localparam logic [7:0] OFF_PSR = 8'h10;
    localparam logic [7:0] OFF_DIVL = 8'h14;
    localparam logic [7:0] OFF_STAT = 8'h18;
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Prescaler select register fields: divisor bits 10:8 sit above.
    localparam int PSR_PRE_LSB = 0;
    localparam int PSR_DIVH_LSB = 5;
    // Character length codes.
    localparam logic [1:0] CHL_EIGHT = 2'h0;
    localparam logic [1:0] CHL_SEVEN = 2'h1;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam logic [3:0] TICK_HALF = 4'h7;
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam int WAKE_DELAY_INSTR = 256;
    localparam logic [8:0] WAKE_DELAY_CYC = 9'(WAKE_DELAY_INSTR - 1);
    localparam logic [9:0] TX_ONES = 10'h3FF;
    localparam logic [12:0] FRAME_ONES = 13'h1FFF;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10
    } spb_rx_e;

    // Line control: bit 0 is the ninth bit or the low parity select.
    typedef struct packed {
        logic [1:0] chl;
        logic pen;
        logic parity_sel_high;
        logic ninth_tx_bit;
    } spb_lcr_s;

    typedef struct packed {
        logic stop2;
        logic sync;
        logic ckx_out;
        logic xrclk;
        logic xtclk;
        logic rx_irq_enable;
        logic tx_irq_enable;
    } spb_icr_s;
endpackage

//--- verilog/spb_core.sv
// Serial port core: baud generator, transmitter, receiver and AXI registers.
// Notes on behaviour
// R01: Shared bit is ninth bit or parity select.
// R02: Receiver needs only one stop bit.
// R03: Software uses same framing both directions.
// R04: Separate receive-full and transmit-empty interrupts.
// R05: Transmit interrupt pending while empty and enabled.
// R06: Receive interrupt pending while full and enabled.
// R07: Each direction picks external or internal clock.
// R08: Half-step prescaler then 11-bit divisor.
// R09: Code zero stops, code k divides (k+1)/2.
// R10: Prescaler zero powers the port down.
// R11: Software stops clock before changing rate.
// R12: Divisor high bits share prescaler register; reset clears.
// R13: Divisor holds value minus one; async divides 16.
// R14: Async rate is clock over 16*N*P.
// R15: Sync rate is clock over 2*N*P.
// R16: Async supports rates up to 625k.
// R17: Low-power entry sets empty, clears status.
// R18: Low-power entry fills transmit shifter with ones.
// R19: Incoming start bit wakes from low power.
// R20: Software arms wakeup on falling receive edge.
// R21: Crystal wake from deep mode waits 256 cycles.
// R22: Finished shifter loads buffer and sets empty.
// R23: Complete character copies to buffer, sets full.
// R24: Clock pin as output carries baud clock.
// R25: Sync drives on rising, samples on falling.
// R26: Half factors alternate floor and ceiling periods.
// R27: Divisor reloads at zero, one pulse each.
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
module spb_core
    import spb_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic receive_pin,
    output logic transmit_pin,
    input wire logic ext_serial_clock_pin_i,
    output logic ext_serial_clock_pin_o,
    output logic ext_serial_clock_pin_oe,
    input wire logic lp_enter,
    input wire logic lp_deep,
    input wire logic xtal_osc,
    output logic wake_req,
    output logic exec_hold,
    output logic tx_irq,
    output logic rx_irq
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    spb_lcr_s lcr;
    spb_icr_s icr;
    spb_rx_e rx_state;
    logic [7:0] prescaler_select_register, divl;
    logic [7:0] tx_holding_buffer, rx_holding_buffer;
    logic [9:0] tx_shift_register, rx_shift_register;
    logic tx_buffer_empty_flag, rx_buffer_full_flag, rx_ninth, fe, pe;
    logic tx_busy, in_lp, rx_prev, ck_prev, sclk, pre_ph, pre_tick;
    logic div_tick, tx_load, tx_bit, rx_tick, rx_sample, rx_done;
    logic [3:0] tx_cnt, tx_sub, rx_sub, rx_cnt, rx_k, tx_k;
    logic [4:0] pre_cnt, pre_len, pre_code;
    logic [5:0] pre_p1;
    logic [10:0] div_cnt, divisor;
    logic [8:0] wait_cnt;
    logic [7:0] aw_addr, w_data;
    logic w_en;
    logic aw_full, w_full, wr_go, wr_txbuf, rd_go, rd_rxbuf;
    logic ext_rise, ext_fall, int_rise, int_fall, tx_edge, rx_edge;
    logic nine, seven, use_par;
    logic [3:0] n_data;
    logic [9:0] rx_next, rx_v;
    logic [12:0] tx_frame;

    function automatic logic spb_par(input logic [7:0] d,
                                     input logic [1:0] sel);
        case (sel)
            2'h0: spb_par = ~^d;
            2'h1: spb_par = ^d;
            2'h2: spb_par = 1'b1;
            default: spb_par = 1'b0;
        endcase
    endfunction

    function automatic logic spb_mapped(input logic [7:0] a);
        spb_mapped = (a[1:0] == 2'h0) && (a <= OFF_STAT);
    endfunction

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready = !w_full && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go = aw_full && w_full && !s_axi_bvalid;
    assign wr_txbuf = wr_go && (aw_addr == OFF_TXBUF);
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign rd_rxbuf = rd_go && (s_axi_araddr == OFF_RXBUF);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            w_en <= 1'b0;
            aw_addr <= RST_REG;
            w_data <= RST_REG;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                w_data <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : RST_REG;
                w_en <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= spb_mapped(aw_addr) ? RESP_OKAY
                                                   : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Only byte lane 0 carries register data; other lanes are ignored.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lcr <= '0;
            icr <= '0;
            prescaler_select_register <= RST_REG; // R12
            divl <= RST_REG;
            tx_holding_buffer <= RST_REG;
        end else if (wr_go && w_en) begin
            case (aw_addr)
                OFF_TXBUF: tx_holding_buffer <= w_data;
                OFF_LCR: lcr <= w_data[4:0];
                OFF_ICR: icr <= w_data[6:0];
                OFF_PSR: prescaler_select_register <= w_data; // R12
                OFF_DIVL: divl <= w_data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= spb_mapped(s_axi_araddr) ? RESP_OKAY
                                                    : RESP_SLVERR;
            case (s_axi_araddr)
                OFF_TXBUF: s_axi_rdata <= {24'h0, tx_holding_buffer};
                OFF_RXBUF: s_axi_rdata <= {24'h0, rx_holding_buffer};
                OFF_LCR: s_axi_rdata <= {27'h0, lcr};
                OFF_ICR: s_axi_rdata <= {25'h0, icr};
                OFF_PSR: s_axi_rdata <= {24'h0, prescaler_select_register};
                OFF_DIVL: s_axi_rdata <= {24'h0, divl};
                OFF_STAT: s_axi_rdata <= {25'h0, in_lp, tx_busy, rx_ninth,
                    pe, fe, rx_buffer_full_flag, tx_buffer_empty_flag};
                default: s_axi_rdata <= '0;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Baud generator
    // ------------------------------------------------------------------
    // Alternating floor and ceiling periods keeps the average exact.
    assign pre_code = prescaler_select_register[PSR_PRE_LSB +: 5];
    assign divisor = {prescaler_select_register[PSR_DIVH_LSB +: 3], divl};
    assign pre_p1 = {1'b0, pre_code} + 6'h01; // R09
    assign pre_len = pre_ph ? 5'((pre_p1 + 6'h01) >> 1)
                            : 5'(pre_p1 >> 1); // R26
    assign pre_tick = (pre_code != 5'h00) &&
                      (pre_cnt == pre_len - 5'h01); // R10

    always_ff @(posedge aclk) begin
        if (!aresetn || pre_code == 5'h00) begin // R10
            pre_cnt <= 5'h00;
            pre_ph <= 1'b0;
        end else if (pre_tick) begin
            pre_cnt <= 5'h00;
            pre_ph <= !pre_ph; // R26
        end else begin
            pre_cnt <= pre_cnt + 5'h01; // R08
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || pre_code == 5'h00) begin
            div_cnt <= 11'h000;
            div_tick <= 1'b0;
            sclk <= 1'b0;
        end else begin
            div_tick <= 1'b0;
            if (pre_tick) begin
                if (div_cnt == 11'h000) begin
                    div_cnt <= divisor; // R27
                    div_tick <= 1'b1; // R13
                    sclk <= !sclk; // R15
                end else begin
                    div_cnt <= div_cnt - 11'h001; // R08
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Clock selection
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ck_prev <= 1'b0;
            rx_prev <= 1'b1;
            ext_serial_clock_pin_o <= 1'b0;
        end else begin
            ck_prev <= ext_serial_clock_pin_i;
            rx_prev <= receive_pin;
            ext_serial_clock_pin_o <= sclk; // R24
        end
    end
    assign ext_serial_clock_pin_oe = icr.ckx_out; // R24
    assign ext_rise = ext_serial_clock_pin_i && !ck_prev;
    assign ext_fall = !ext_serial_clock_pin_i && ck_prev;
    assign int_rise = div_tick && sclk;
    assign int_fall = div_tick && !sclk;
    // Async counts x16 ticks; sync uses serial clock edges.
    assign tx_edge = icr.sync ? (icr.xtclk ? ext_rise : int_rise)
                              : (icr.xtclk ? ext_rise : div_tick); // R07
    assign rx_edge = icr.sync ? (icr.xrclk ? ext_fall : int_fall)
                              : (icr.xrclk ? ext_rise : div_tick); // R07
    assign tx_bit = tx_edge && (icr.sync || tx_sub == TICK_LAST); // R25
    assign rx_tick = rx_edge; // R16

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    assign nine = lcr.chl[1];
    assign seven = (lcr.chl == CHL_SEVEN);
    assign use_par = lcr.pen && !nine;
    assign n_data = nine ? 4'h9 : (seven ? 4'h7 : 4'h8);
    assign tx_k = 4'(n_data + {3'h0, use_par} + {3'h0, icr.stop2} + 4'h2);

    always_comb begin
        tx_frame = FRAME_ONES << 1;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < n_data) begin
                tx_frame[i + 1] = tx_holding_buffer[i];
            end
        end
        if (nine) begin
            tx_frame[9] = lcr.ninth_tx_bit; // R01
        end
        if (use_par) begin
            tx_frame[n_data + 4'h1] = spb_par(seven ?
                {1'b0, tx_holding_buffer[6:0]} : tx_holding_buffer,
                {lcr.parity_sel_high, lcr.ninth_tx_bit}); // R01
        end
    end

    // A write to the buffer holds off the load for one cycle.
    assign tx_load = !tx_buffer_empty_flag && !wr_txbuf &&
                     (!tx_busy || (tx_bit && tx_cnt == 4'h1)); // R22

    always_ff @(posedge aclk) begin
        if (!aresetn || lp_enter) begin
            tx_shift_register <= TX_ONES; // R18
            tx_busy <= 1'b0;
            tx_cnt <= 4'h0;
            tx_sub <= 4'h0;
        end else begin
            if (tx_edge) begin
                tx_sub <= tx_sub + 4'h1; // R13
            end
            if (tx_load) begin
                tx_shift_register <= tx_frame[9:0]; // R22
                tx_busy <= 1'b1;
                tx_cnt <= tx_k;
                tx_sub <= 4'h0;
            end else if (tx_busy && tx_bit) begin
                tx_shift_register <= {1'b1, tx_shift_register[9:1]}; // R14
                tx_cnt <= tx_cnt - 4'h1;
                tx_busy <= (tx_cnt != 4'h1);
            end
        end
    end
    assign transmit_pin = tx_shift_register[0];

    always_ff @(posedge aclk) begin
        if (!aresetn || lp_enter) begin
            tx_buffer_empty_flag <= 1'b1; // R17
        end else if (tx_load) begin
            tx_buffer_empty_flag <= 1'b1; // R22
        end else if (wr_txbuf) begin
            tx_buffer_empty_flag <= 1'b0; // R22
        end
    end

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    assign rx_k = 4'(n_data + {3'h0, use_par} + 4'h1); // R02
    assign rx_sample = (rx_state == RX_DATA) && rx_tick &&
                       (icr.sync || rx_sub == TICK_LAST);
    assign rx_done = rx_sample && (rx_cnt == rx_k - 4'h1); // R23
    assign rx_next = {receive_pin, rx_shift_register[9:1]};
    assign rx_v = rx_next >> (4'hA - rx_k);

    always_ff @(posedge aclk) begin
        if (!aresetn || lp_enter) begin
            rx_state <= RX_IDLE;
            rx_sub <= 4'h0;
            rx_cnt <= 4'h0;
        end else if (rx_tick) begin
            rx_sub <= rx_sub + 4'h1;
            case (rx_state)
                RX_IDLE: begin
                    if (!receive_pin) begin
                        rx_state <= icr.sync ? RX_DATA : RX_START;
                        rx_sub <= icr.sync ? 4'h0 : 4'h1;
                        rx_cnt <= 4'h0;
                    end
                end
                RX_START: begin
                    if (rx_sub == TICK_HALF) begin
                        rx_state <= receive_pin ? RX_IDLE : RX_DATA;
                        rx_sub <= 4'h0;
                    end
                end
                RX_DATA: begin
                    if (rx_sample) begin
                        rx_cnt <= rx_cnt + 4'h1;
                        if (rx_done) begin
                            rx_state <= RX_IDLE; // R02
                        end
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_shift_register <= TX_ONES;
        end else if (rx_sample && !lp_enter) begin
            rx_shift_register <= rx_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_holding_buffer <= RST_REG;
        end else if (rx_done && !lp_enter) begin
            rx_holding_buffer <= seven ? {1'b0, rx_v[6:0]} : rx_v[7:0];
        end
    end

    // New characters win over a clearing read in the same cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn || lp_enter) begin
            rx_buffer_full_flag <= 1'b0; // R17
            fe <= 1'b0;
            pe <= 1'b0;
            rx_ninth <= 1'b0;
        end else if (rx_done) begin
            rx_buffer_full_flag <= 1'b1; // R23
            fe <= !rx_v[rx_k - 4'h1];
            pe <= use_par && (rx_v[n_data] != spb_par(seven ?
                {1'b0, rx_v[6:0]} : rx_v[7:0],
                {lcr.parity_sel_high, lcr.ninth_tx_bit}));
            rx_ninth <= nine && rx_v[8];
        end else if (rd_rxbuf) begin
            rx_buffer_full_flag <= 1'b0; // R23
            fe <= 1'b0;
            pe <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Interrupts and low power
    // ------------------------------------------------------------------
    assign tx_irq = tx_buffer_empty_flag && icr.tx_irq_enable; // R04 R05
    assign rx_irq = rx_buffer_full_flag && icr.rx_irq_enable; // R04 R06

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_lp <= 1'b0;
            wake_req <= 1'b0;
            exec_hold <= 1'b0;
            wait_cnt <= 9'h000;
        end else begin
            wake_req <= 1'b0;
            if (lp_enter) begin
                in_lp <= 1'b1;
                exec_hold <= lp_deep && xtal_osc;
            end else if (in_lp && rx_prev && !receive_pin) begin
                in_lp <= 1'b0; // R19
                wake_req <= 1'b1; // R19
                wait_cnt <= WAKE_DELAY_CYC; // R21
            end else if (!in_lp && exec_hold) begin
                // The oscillator may still be settling, so code waits.
                if (wait_cnt == 9'h000) begin
                    exec_hold <= 1'b0; // R21
                end else begin
                    wait_cnt <= wait_cnt - 9'h001; // R21
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_NINTH: assert property (@(posedge aclk) disable iff (!aresetn) // R01
        tx_load && nine |=> tx_shift_register[9] == $past(lcr.ninth_tx_bit))
        else $error("ninth bit not framed");
    AST_TX_IRQ: assert property (@(posedge aclk) disable iff (!aresetn) // R05
        wr_txbuf && !tx_load |=> !tx_irq)
        else $error("tx interrupt not removed by write");
    AST_RX_IRQ: assert property (@(posedge aclk) disable iff (!aresetn) // R06
        rx_done && icr.rx_irq_enable && !lp_enter |=> rx_irq)
        else $error("rx interrupt not raised");
    AST_PRE_OFF: assert property (@(posedge aclk) disable iff (!aresetn) // R10
        pre_code == 5'h00 |=> !div_tick)
        else $error("baud clock ran with prescaler off");
    AST_LP_TX_SHIFT_REGISTER: assert property (@(posedge aclk) disable iff (!aresetn) // R18
        lp_enter |=> tx_shift_register == TX_ONES && tx_buffer_empty_flag
        && !rx_buffer_full_flag)
        else $error("low power entry did not reinitialise");
    AST_WAKE: assert property (@(posedge aclk) disable iff (!aresetn) // R19
        in_lp && !lp_enter && rx_prev && !receive_pin |=> wake_req && !in_lp)
        else $error("start bit did not wake");
    AST_DELAY: assert property (@(posedge aclk) disable iff (!aresetn) // R21
        wake_req && exec_hold |-> exec_hold [*8])
        else $error("wake delay ended early");
    AST_TX_BUFFER_EMPTY_FLAG: assert property (@(posedge aclk) disable iff (!aresetn) // R22
        tx_load |=> tx_buffer_empty_flag && tx_busy && !transmit_pin)
        else $error("buffer not moved to shifter");
    AST_RX_HOLDING_BUFFER: assert property (@(posedge aclk) disable iff (!aresetn) // R23
        rx_done && !lp_enter |=> rx_buffer_full_flag)
        else $error("received character not flagged");
endmodule // spb_core

//--- test/spb_peer.sv
// Remote serial peer: drives the receive line, samples the transmit line.
module spb_peer (
    input wire logic aclk,
    input wire logic line_in,
    output logic line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial line_out = 1'b1;
    // Start, eight data bits LSB first, one stop, as the port is framed.
    task automatic send(input logic [7:0] d, input int bt);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out <= f[i];
            repeat (bt) @(posedge aclk);
        end
    endtask
    // Samples mid-bit; the stop bits are not looked at.
    task automatic recv(input int n, input int bt, output logic [8:0] d);
        d = '0;
        @(negedge line_in);
        repeat (bt / 2) @(posedge aclk);
        for (int i = 0; i < n; i++) begin
            repeat (bt) @(posedge aclk);
            d[i] = line_in;
        end
    endtask
endmodule // spb_peer

//--- test/serial_port_baud_irq_sleep_tb.sv
// Testbench: register-level tests of the serial port against a line peer.
module serial_port_baud_irq_sleep_tb;
    import spb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // Prescale 1.5 and divisor 2 give 16 * 2 * 1.5 aclk per bit.
    localparam int BT = 48;
    // The pin clock gives one x16 tick every 2 aclk, so 32 aclk per bit.
    localparam int BT_EXT = 32;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, rx_line, tx_line;
    logic ck_i, lp_enter, lp_deep, xtal, wake_req, exec_hold;
    logic tx_irq, rx_irq, ck_o, ck_oe;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v, n;
    logic [1:0] bresp, rresp, r;
    logic [8:0] pb;
    int n_fail, samples_checked;
    spb_core i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .receive_pin(rx_line), .transmit_pin(tx_line),
        .ext_serial_clock_pin_i(ck_i), .ext_serial_clock_pin_o(ck_o),
        .ext_serial_clock_pin_oe(ck_oe), .lp_enter(lp_enter),
        .lp_deep(lp_deep), .xtal_osc(xtal), .wake_req(wake_req),
        .exec_hold(exec_hold), .tx_irq(tx_irq), .rx_irq(rx_irq));
    spb_peer i_peer (.aclk(aclk), .line_in(tx_line), .line_out(rx_line));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) ck_i <= (ck_i === 1'b0);
    task automatic print_verdict();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && awready === 1'b1) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        chk("bresp", 32'(RESP_OKAY), 32'(bresp));
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        v = rdata;
        r = rresp;
    endtask
    task automatic rchk(input string s, input logic [7:0] a, logic [31:0] e);
        rd(a);
        chk(s, e, v);
    endtask
    task automatic wait_rx();
        for (int i = 0; i < 200 && rx_irq !== 1'b1; i++) @(posedge aclk);
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        print_verdict();
    end
    initial begin
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, arvalid, lp_enter, lp_deep, xtal} = '0;
        {bready, rready} = 2'b11;
        n_fail = 0;
        samples_checked = 0;
        aresetn = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rchk("stat", OFF_STAT, 32'h1);
        rchk("psr", OFF_PSR, 32'h0);
        rd(8'h1C);
        chk("rresp", 32'(RESP_SLVERR), 32'(r));
        wr(OFF_ICR, 32'h01);
        chk("tx_irq", 32'h1, 32'(tx_irq));
        wr(OFF_ICR, 32'h52);
        chk("tx_irq", 32'h0, 32'(tx_irq));
        chk("ck_oe", 32'h1, 32'(ck_oe));
        // The rate is set while the prescaler still reads zero.
        wr(OFF_DIVL, 32'h01);
        wr(OFF_PSR, 32'h02);
        n = '0;
        repeat (48) begin
            v = 32'(ck_o);
            @(posedge aclk);
            n = n + 32'(ck_o != v[0]);
        end
        chk("ck_o", 32'd16, n);
        i_peer.send(8'hA5, BT);
        wait_rx();
        chk("rx_irq", 32'h1, 32'(rx_irq));
        rchk("rxbuf", OFF_RXBUF, 32'hA5);
        chk("rx_irq", 32'h0, 32'(rx_irq));
        fork
            i_peer.recv(8, BT, pb);
            wr(OFF_TXBUF, 32'h3C);
        join
        chk("tx8", 32'h3C, 32'(pb));
        repeat (3 * BT) @(posedge aclk);
        wr(OFF_LCR, 32'h11);
        fork
            i_peer.recv(9, BT, pb);
            wr(OFF_TXBUF, 32'h5A);
        join
        chk("tx9", 32'h15A, 32'(pb));
        wr(OFF_LCR, 32'h05);
        fork
            i_peer.recv(9, BT, pb);
            wr(OFF_TXBUF, 32'h5B);
        join
        chk("par", 32'h15B, 32'(pb));
        // Peer frames eight bits, so the port must too; rx runs off the pin.
        wr(OFF_LCR, 32'h00);
        wr(OFF_ICR, 32'h5A);
        i_peer.send(8'h96, BT_EXT);
        wait_rx();
        chk("rx_irq", 32'h1, 32'(rx_irq));
        lp_deep <= 1'b1;
        xtal <= 1'b1;
        lp_enter <= 1'b1;
        @(posedge aclk);
        lp_enter <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("rx_irq", 32'h0, 32'(rx_irq));
        chk("txpin", 32'h1, 32'(tx_line));
        rchk("rxbuf", OFF_RXBUF, 32'h96);
        fork
            i_peer.send(8'h00, BT);
            begin
                for (int i = 0; i < 50 && wake_req !== 1'b1; i++)
                    @(posedge aclk);
                chk("wake", 32'h1, 32'(wake_req));
                n = 32'(exec_hold);
                repeat (300) begin
                    @(posedge aclk);
                    n = n + 32'(exec_hold);
                end
                chk("hold", 32'd256, n);
            end
        join
        wr(OFF_PSR, 32'h00);
        // With no baud clock the start bit is held and no data bit follows.
        wr(OFF_TXBUF, 32'hFF);
        repeat (2 * BT) begin
            @(posedge aclk);
            chk("stopped", 32'h0, 32'(tx_line));
        end
        print_verdict();
    end
endmodule // serial_port_baud_irq_sleep_tb
